// [tb/can_engine_model.sv]
// Behavioural protocol engine that takes offers and reports outcomes
`timescale 1ns/1ps
module can_engine_model (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire can_buf_pkg::tx_req_s tx_req_in,
    input wire logic [5:0] abort_req_in,
    input wire logic hold_in,
    input wire logic [1:0] kind_in,
    input wire logic [3:0] lat_in,
    output logic busy_out,
    output logic res_valid_out,
    output can_buf_pkg::tx_result_s res_out
);
    logic sending_ff;
    logic [3:0] cnt_ff;
    logic [2:0] idx_ff;
    logic [6:0] noise_ff;
    logic ab;
    // Hold keeps the bus busy so several buffers can queue up
    assign busy_out = hold_in | sending_ff;
    assign ab = abort_req_in[idx_ff];
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sending_ff <= 1'b0;
            cnt_ff <= 4'h0;
            idx_ff <= 3'h0;
            noise_ff <= 7'h00;
            res_valid_out <= 1'b0;
            res_out <= '0;
        end else begin
            noise_ff <= noise_ff + 7'h5B;
            res_valid_out <= 1'b0;
            // Outcome lines never keep a stale value outside the pulse
            res_out <= can_buf_pkg::tx_result_s'(~noise_ff);
            if (tx_req_in.valid && !busy_out) begin
                sending_ff <= 1'b1;
                cnt_ff <= lat_in;
                idx_ff <= tx_req_in.buf_idx;
            end else if (sending_ff && (cnt_ff == 4'h0 || ab)) begin
                sending_ff <= 1'b0;
                res_valid_out <= 1'b1;
                res_out <= {idx_ff, kind_in == 2'h0 && !ab, ab, kind_in == 2'h1 && !ab,
                    kind_in == 2'h2 && !ab};
            end else if (sending_ff) begin
                cnt_ff <= cnt_ff - 4'h1;
            end
        end
    end
endmodule

// [tb/can_prog_buffers_chk.sv]
// Port-level assertions for the programmable CAN buffers
`timescale 1ns/1ps
module can_prog_buffers_chk (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [6:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    input wire can_buf_pkg::tx_req_s tx_req_out,
    input wire logic tx_busy_in,
    input wire logic tx_result_valid_in,
    input wire logic [5:0] abort_req_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // ------------------------------
    // Shadow of mode and sending state
    // ------------------------------
    logic [1:0] mode_ff;
    logic send_ff;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_ff <= 2'h0;
        end else if (wr_in && addr_in == can_buf_pkg::ADDR_MODE) begin
            mode_ff <= wdata_in[1:0];
        end
    end
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            send_ff <= 1'b0;
        end else begin
            send_ff <= (send_ff && !tx_result_valid_in) || (tx_req_out.valid && !tx_busy_in);
        end
    end
    // ------------------------------
    // Properties
    // ------------------------------
    sequence s_read_zero;
        ##1 rdata_out == 8'h00;
    endsequence
    sequence s_abort_kept;
        ##1 $stable(abort_req_out);
    endsequence
    property p_legacy_rd; rd_in && addr_in < 7'h60 && mode_ff == 2'h0 |-> s_read_zero; endproperty
    a_legacy_rd: assert property (p_legacy_rd) else $error("buffer read not zero");
    property p_legacy_tx; mode_ff == can_buf_pkg::MODE_LEGACY |-> !tx_req_out.valid; endproperty
    a_legacy_tx: assert property (p_legacy_tx) else $error("offer in mode 0");
    property p_unimpl; rd_in && addr_in[1:0] == 2'h3 |-> s_read_zero; endproperty
    a_unimpl: assert property (p_unimpl) else $error("unmapped read not zero");
    property p_idl_gap;
        rd_in && addr_in < 7'h60 && addr_in[1:0] == 2'h2 |=> !rdata_out[2];
    endproperty
    a_idl_gap: assert property (p_idl_gap) else $error("id low bit 2 set");
    property p_one_offer; send_ff && !tx_result_valid_in |-> !tx_req_out.valid; endproperty
    a_one_offer: assert property (p_one_offer) else $error("offer while sending");
    property p_offer_idle; tx_req_out.valid |-> !tx_busy_in; endproperty
    a_offer_idle: assert property (p_offer_idle) else $error("offer while busy");
    property p_abort_hold; (|abort_req_out) && !tx_result_valid_in |-> s_abort_kept; endproperty
    a_abort_hold: assert property (p_abort_hold) else $error("abort dropped early");
    property p_abort_send; (|abort_req_out) |-> send_ff; endproperty
    a_abort_send: assert property (p_abort_send) else $error("abort while idle");
endmodule
bind can_prog_buffers can_prog_buffers_chk u_chk (.clk_in, .rst_n_in, .addr_in, .wdata_in,
    .wr_in, .rd_in, .rdata_out, .tx_req_out, .tx_busy_in, .tx_result_valid_in, .abort_req_out);

// [tb/can_prog_buffers_tb.sv]
// Self-checking testbench for the programmable CAN buffers
`timescale 1ns/1ps
module can_prog_buffers_tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [6:0] addr_in = 7'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic rx_valid_in = 1'b0;
    logic hold = 1'b1;
    logic [1:0] kind = 2'h0;
    logic [3:0] lat = 4'h3;
    logic [7:0] rdata_out;
    logic tx_busy_in;
    logic tx_result_valid_in;
    logic [5:0] abort_req_out;
    can_buf_pkg::rx_frame_s rx_frame_in = '0;
    can_buf_pkg::tx_req_s tx_req_out;
    can_buf_pkg::tx_result_s tx_result_in;
    int error_cnt = 0;
    int checks = 0;
    int tid[6];
    int offer_q[$];
    logic [15:0] seed = 16'hFF70;
    logic [28:0] id = '0;
    always #20 clk_in = ~clk_in;
    can_prog_buffers dut (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
        .rx_valid_in, .rx_frame_in, .tx_req_out, .tx_busy_in, .tx_result_valid_in,
        .tx_result_in, .abort_req_out);
    can_engine_model eng (.clk_in, .rst_n_in, .tx_req_in(tx_req_out), .abort_req_in(abort_req_out),
        .hold_in(hold), .kind_in(kind), .lat_in(lat), .busy_out(tx_busy_in),
        .res_valid_out(tx_result_valid_in), .res_out(tx_result_in));
    // ------------------------------
    // Tasks
    // ------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk({24'h0, rdata_out & m}, {24'h0, exp});
    endtask
    task automatic rx(input logic [2:0] b, input logic [4:0] fl, input logic [4:0] fi);
        @(posedge clk_in);
        rx_frame_in <= can_buf_pkg::rx_frame_s'({b, id, fl, fi});
        rx_valid_in <= 1'b1;
        @(posedge clk_in);
        rx_frame_in <= ~rx_frame_in;
        rx_valid_in <= 1'b0;
    endtask
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic new_id();
        seed = lfsr(seed);
        id[28:16] = seed[12:0];
        seed = lfsr(seed);
        id[15:0] = seed;
    endtask
    task automatic wait_res();
        int n = 0;
        while (tx_result_valid_in !== 1'b1 && n < 300) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (n >= 300) begin
            error_cnt++;
            end_sim();
        end else begin
            @(posedge clk_in);
            #1;
        end
    endtask
    // Every offer the engine takes must match the next entry queued in offer_q, both buffer and identifier
    always @(posedge clk_in) begin
        if (rst_n_in && tx_req_out.valid === 1'b1 && tx_busy_in === 1'b0) begin
            if (offer_q.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                chk({29'h0, tx_req_out.buf_idx}, offer_q[0]);
                chk({20'h0, tx_req_out.ext, tx_req_out.id[10:0]},
                    tid[offer_q.pop_front()]);
            end
        end
    end
    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        rd(7'h00, 8'h00, 8'hFF);
        wr(7'h31, 8'hA5);
        rd(7'h31, 8'h00, 8'hFF);
        wr(can_buf_pkg::ADDR_MODE, 8'h01);
        wr(can_buf_pkg::ADDR_DIR, 8'h38);
        rd(7'h13, 8'h00, 8'hFF);
        new_id();
        rx(3'h0, 5'b00111, 5'h0F);
        rd(7'h00, 8'h8F, 8'hFF);
        rd(7'h01, id[10:3], 8'hFF);
        rd(7'h02, {id[2:0], 5'h00}, 8'hFF);
        rx(3'h0, 5'b00011, 5'h02);
        rd(7'h00, 8'h8F, 8'hFF);
        wr(7'h00, 8'h00);
        rx(3'h0, 5'b00010, 5'h02);
        rx(3'h0, 5'b00001, 5'h02);
        // Filter number of the last stored frame survives the clear
        rd(7'h00, 8'h0F, 8'hFF);
        wr(7'h00, 8'h40);
        new_id();
        rx(3'h0, 5'b11101, 5'h05);
        rd(7'h00, 8'hE0, 8'hE0);
        rd(7'h01, id[28:21], 8'hFF);
        rd(7'h02, {id[20:18], 3'b110, id[17:16]}, 8'hFF);
        for (int k = 0; k < 16; k++) begin
            rx(3'h1, 5'b00011, k[4:0]);
            rd(7'h10, {3'b100, k[4:0]}, 8'hFF);
            wr(7'h10, 8'h00);
        end
        rx(3'h3, 5'b00011, 5'h01);
        rd(7'h30, 8'h00, 8'hFF);
        for (int b = 3; b < 6; b++) begin
            new_id();
            wr(7'(b * 16 + 1), id[7:0]);
            wr(7'(b * 16 + 2), 8'hF7);
            tid[b] = int'({id[7:0], 3'b111});
        end
        rd(7'h32, 8'hE3, 8'hFF);
        wr(7'h30, 8'h09);
        wr(7'h40, 8'h0B);
        wr(7'h50, 8'h0A);
        offer_q = '{4, 5, 3};
        wr(7'h31, 8'h00);
        rd(7'h31, 8'(tid[3] >> 3), 8'hFF);
        hold <= 1'b0;
        repeat (3) wait_res();
        rd(7'h30, 8'h81, 8'hFF);
        rd(7'h40, 8'h83, 8'hFF);
        rd(7'h50, 8'h82, 8'hFF);
        lat <= 4'h8;
        for (int k = 1; k < 3; k++) begin
            hold <= 1'b0;
            kind <= 2'(k);
            offer_q.push_back(3);
            wr(7'h30, 8'h09);
            repeat (3) @(posedge clk_in);
            hold <= 1'b1;
            rd(can_buf_pkg::ADDR_TX_STAT, 8'h08, 8'hFF);
            wait_res();
            rd(7'h30, 8'(8'h40 >> k), 8'h70);
            wr(7'h30, 8'h01);
            rd(7'h30, 8'h00, 8'h08);
        end
        kind <= 2'h0;
        wr(7'h30, 8'h09);
        wr(7'h30, 8'h01);
        rd(7'h30, 8'h40, 8'h78);
        hold <= 1'b0;
        offer_q.push_back(3);
        wr(7'h30, 8'h09);
        repeat (3) @(posedge clk_in);
        wr(7'h30, 8'h01);
        wait_res();
        rd(7'h30, 8'h40, 8'h78);
        rx(3'h3, 5'b01011, 5'h00);
        rd(7'h30, 8'h00, 8'h08);
        wr(7'h30, 8'h05);
        offer_q.push_back(3);
        rx(3'h3, 5'b01011, 5'h00);
        wait_res();
        rd(7'h30, 8'h85, 8'h8F);
        end_sim();
    end
endmodule

// [verilog/can_buf_pkg.sv]
// Package: register map, field layouts and carrier types for the six CAN message buffers
package can_buf_pkg;

    localparam int NUM_BUFS = 6;

    // Register index inside one buffer's window
    localparam logic [1:0] REG_CON = 2'h0;
    localparam logic [1:0] REG_IDH = 2'h1;
    localparam logic [1:0] REG_IDL = 2'h2;
    // Address layout: addr[6:4] selects buffer, addr[1:0] register
    localparam logic [6:0] ADDR_DIR = 7'h70;
    localparam logic [6:0] ADDR_MODE = 7'h71;
    localparam logic [6:0] ADDR_TX_STAT = 7'h72;
    localparam int BUF_SEL_LSB = 4;

    // Control byte, receive view
    localparam int RX_FULL_BIT = 7;
    localparam int RX_ALL_BIT = 6;
    localparam int RX_RTR_BIT = 5;
    // Control byte, transmit view
    localparam int TX_DONE_BIT = 7;
    localparam int TX_ABT_BIT = 6;
    localparam int TX_LARB_BIT = 5;
    localparam int TX_ERR_BIT = 4;
    localparam int TX_REQ_BIT = 3;
    localparam int TX_AUTO_ANS_BIT = 2;
    // Identifier low byte
    localparam int IDL_SRR_BIT = 4;
    localparam int IDL_EXT_BIT = 3;
    localparam logic [7:0] IDL_TX_MASK = 8'hEB;

    localparam logic [1:0] MODE_LEGACY = 2'h0;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Received frame handed over by the protocol engine
    typedef struct packed {
        logic [2:0] buf_idx;
        logic [28:0] id;
        logic ext;
        logic rtr;
        logic substitute_remote_bit;
        logic valid_msg;
        logic filter_hit;
        logic [4:0] filter_idx;
    } rx_frame_s;

    // Outgoing request towards the protocol engine
    typedef struct packed {
        logic valid;
        logic [2:0] buf_idx;
        logic [28:0] id;
        logic ext;
    } tx_req_s;

    // Transmission outcome reported by the protocol engine
    typedef struct packed {
        logic [2:0] buf_idx;
        logic done;
        logic aborted;
        logic arb_lost;
        logic bus_error;
    } tx_result_s;

endpackage

// [verilog/can_prog_buffers.sv]
// Six programmable CAN transmit/receive message buffers with register port
`timescale 1ns/1ps

// What this block does
// - Six buffers, each direction set by its own bit, each able to auto-answer remotes.
// - Buffers act only in the enhanced modes 1 to 3; unused in mode zero.
// - Full flag set on store; no new load while set; software clears it.
// - Accept-all takes every message ignoring filters; otherwise valid filter hits only.
// - Receive remote flag shows whether stored message was a remote request.
// - Five-bit field records the admitting filter number, 0 to 31.
// - Done flag set on successful transmission.
// - Aborted flag set when pending message was aborted instead of sent.
// - Arbitration-lost flag set when message loses arbitration while sent.
// - Bus-error flag set when an error occurs while message is sent.
// - Setting request clears aborted, lost, error flags; request clears on success.
// - With auto answer on, a received remote sets the request bit itself.
// - Two-bit priority orders pending buffers, 11 highest; identifier untouched.
// - Identifier registers and control bits other than request ignore writes while request set or sending.
// - High identifier byte holds standard 10..3 or extended 28..21.
// - Low byte 7..5 holds id 2..0 or 20..18; bits 1..0 extended 17..16.
// - Received extended flag is 1 for 29-bit identifier frames, else 0.
// - Substitute remote bit recorded for extended frames only.
// - Unimplemented identifier and control bits read as zero.
module can_prog_buffers (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [6:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic rx_valid_in,
    input wire can_buf_pkg::rx_frame_s rx_frame_in,
    output can_buf_pkg::tx_req_s tx_req_out,
    input wire logic tx_busy_in,
    input wire logic tx_result_valid_in,
    input wire can_buf_pkg::tx_result_s tx_result_in,
    output logic [5:0] abort_req_out
);
    localparam int N = can_buf_pkg::NUM_BUFS;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [N-1:0] dir_tx_ff;
    logic [1:0] mode_ff;
    logic [7:0] con_ff [N];
    logic [7:0] idh_ff [N];
    logic [7:0] idl_ff [N];
    logic [N-1:0] abort_ff;
    logic [N-1:0] sending_ff;
    logic [7:0] rdata_ff;

    logic enhanced;
    logic pick_found;
    logic [2:0] pick_idx;
    logic [N-1:0] pending;
    logic [2*N-1:0] prio_vec;
    logic [2:0] wr_buf;
    logic [1:0] wr_reg;
    logic rx_take;
    logic [2:0] rx_b;

    assign enhanced = (mode_ff != can_buf_pkg::MODE_LEGACY);
    assign wr_buf = addr_in[can_buf_pkg::BUF_SEL_LSB +: 3];
    assign wr_reg = addr_in[1:0];
    assign rx_b = rx_frame_in.buf_idx;

    // Reassemble a 29-bit identifier from the two visible identifier bytes
    function automatic logic [28:0] pack_id(input logic [7:0] h, input logic [7:0] l);
        pack_id = {h, l[7:5], l[1:0], 16'h0000};
    endfunction

    // Buffer may take a frame only if configured receive and empty
    function automatic logic rx_accept(input logic [7:0] c, input logic is_tx,
                                       input can_buf_pkg::rx_frame_s f);
        rx_accept = !is_tx && !c[can_buf_pkg::RX_FULL_BIT] &&
            (c[can_buf_pkg::RX_ALL_BIT] || (f.valid_msg && f.filter_hit));
    endfunction

    assign rx_take = enhanced && rx_valid_in && (int'(rx_b) < N) &&
        rx_accept(con_ff[rx_b], dir_tx_ff[rx_b], rx_frame_in);

    // ------------------------------------------------------------
    // Arbitration among pending transmit buffers
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < N; i++) begin
            pending[i] = enhanced && dir_tx_ff[i] && con_ff[i][can_buf_pkg::TX_REQ_BIT] &&
                !sending_ff[i];
            prio_vec[2*i +: 2] = con_ff[i][1:0];
        end
    end

    tx_prio_pick u_pick (
        .pending_in(pending),
        .prio_in(prio_vec),
        .found_out(pick_found),
        .idx_out(pick_idx)
    );

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dir_tx_ff <= '0;
            mode_ff <= can_buf_pkg::MODE_LEGACY;
        end else if (wr_in && addr_in == can_buf_pkg::ADDR_DIR) begin
            dir_tx_ff <= wdata_in[N-1:0];
        end else if (wr_in && addr_in == can_buf_pkg::ADDR_MODE) begin
            mode_ff <= wdata_in[1:0];
        end
    end

    // ------------------------------------------------------------
    // Per-buffer control and identifier registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < N; i++) begin
                con_ff[i] <= can_buf_pkg::RESET_BYTE;
                idh_ff[i] <= can_buf_pkg::RESET_BYTE;
                idl_ff[i] <= can_buf_pkg::RESET_BYTE;
            end
            abort_ff <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                logic hw_rx;
                logic sw_wr;
                logic locked;
                logic res_me;
                logic [7:0] c;
                hw_rx = rx_take && (int'(rx_b) == i);
                sw_wr = wr_in && (int'(wr_buf) == i) && enhanced &&
                    addr_in[6:4] != 3'h7 && addr_in[3:2] == 2'h0;
                locked = con_ff[i][can_buf_pkg::TX_REQ_BIT] || sending_ff[i];
                res_me = tx_result_valid_in && (int'(tx_result_in.buf_idx) == i);
                c = con_ff[i];
                if (!dir_tx_ff[i]) begin
                    // Receive view: software may clear full and set accept-all
                    if (sw_wr && wr_reg == can_buf_pkg::REG_CON) begin
                        if (!wdata_in[can_buf_pkg::RX_FULL_BIT]) begin
                            c[can_buf_pkg::RX_FULL_BIT] = 1'b0;
                        end
                        c[can_buf_pkg::RX_ALL_BIT] = wdata_in[can_buf_pkg::RX_ALL_BIT];
                    end
                    // Store wins over a simultaneous clear
                    if (hw_rx) begin
                        c[can_buf_pkg::RX_FULL_BIT] = 1'b1;
                        c[can_buf_pkg::RX_RTR_BIT] = rx_frame_in.rtr;
                        c[4:0] = rx_frame_in.filter_idx;
                        idh_ff[i] <= rx_frame_in.ext ? rx_frame_in.id[28:21]
                                                     : rx_frame_in.id[10:3];
                        idl_ff[i] <= rx_frame_in.ext ?
                            {rx_frame_in.id[20:18], rx_frame_in.substitute_remote_bit, 1'b1, 1'b0,
                             rx_frame_in.id[17:16]} :
                            {rx_frame_in.id[2:0], 5'h00};
                    end
                    abort_ff[i] <= 1'b0;
                end else begin
                    // Transmit view
                    if (sw_wr && wr_reg == can_buf_pkg::REG_CON) begin
                        if (!locked) begin
                            c[can_buf_pkg::TX_DONE_BIT] = wdata_in[can_buf_pkg::TX_DONE_BIT];
                            c[2:0] = wdata_in[2:0];
                        end
                        if (wdata_in[can_buf_pkg::TX_REQ_BIT] && !c[can_buf_pkg::TX_REQ_BIT]) begin
                            c[can_buf_pkg::TX_REQ_BIT] = 1'b1;
                            c[6:4] = 3'h0;
                        end else if (!wdata_in[can_buf_pkg::TX_REQ_BIT] &&
                                     c[can_buf_pkg::TX_REQ_BIT]) begin
                            abort_ff[i] <= 1'b1;
                        end
                    end
                    if (sw_wr && !locked && wr_reg == can_buf_pkg::REG_IDH) begin
                        idh_ff[i] <= wdata_in;
                    end
                    if (sw_wr && !locked && wr_reg == can_buf_pkg::REG_IDL) begin
                        idl_ff[i] <= wdata_in & can_buf_pkg::IDL_TX_MASK;
                    end
                    // Pending abort with nothing on the wire completes at once
                    if (abort_ff[i] && !sending_ff[i]) begin
                        c[can_buf_pkg::TX_REQ_BIT] = 1'b0;
                        c[can_buf_pkg::TX_ABT_BIT] = 1'b1;
                        abort_ff[i] <= 1'b0;
                    end
                    if (res_me) begin
                        if (tx_result_in.done) begin
                            c[can_buf_pkg::TX_DONE_BIT] = 1'b1;
                            c[can_buf_pkg::TX_REQ_BIT] = 1'b0;
                            abort_ff[i] <= 1'b0;
                        end
                        if (tx_result_in.aborted) begin
                            c[can_buf_pkg::TX_ABT_BIT] = 1'b1;
                            c[can_buf_pkg::TX_REQ_BIT] = 1'b0;
                            abort_ff[i] <= 1'b0;
                        end
                        if (tx_result_in.arb_lost) begin
                            c[can_buf_pkg::TX_LARB_BIT] = 1'b1;
                        end
                        if (tx_result_in.bus_error) begin
                            c[can_buf_pkg::TX_ERR_BIT] = 1'b1;
                        end
                    end
                    // Remote request for this buffer's identifier
                    if (enhanced && rx_valid_in && rx_frame_in.rtr && int'(rx_b) == i &&
                        c[can_buf_pkg::TX_AUTO_ANS_BIT] && !c[can_buf_pkg::TX_REQ_BIT]) begin
                        c[can_buf_pkg::TX_REQ_BIT] = 1'b1;
                        c[6:4] = 3'h0;
                    end
                end
                con_ff[i] <= c;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmission tracking
    // ------------------------------------------------------------
    // A buffer is marked sending from hand-over until the engine reports an outcome
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sending_ff <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (tx_result_valid_in && int'(tx_result_in.buf_idx) == i) begin
                    sending_ff[i] <= 1'b0;
                end else if (pick_found && !tx_busy_in && !(|sending_ff) &&
                             int'(pick_idx) == i) begin
                    sending_ff[i] <= 1'b1;
                end
            end
        end
    end

    // Identifier sent is the buffer's own, priority never enters it
    always_comb begin
        tx_req_out.valid = pick_found && !tx_busy_in && !(|sending_ff);
        tx_req_out.buf_idx = pick_idx;
        tx_req_out.id = pack_id(idh_ff[pick_idx], idl_ff[pick_idx]);
        tx_req_out.ext = idl_ff[pick_idx][can_buf_pkg::IDL_EXT_BIT];
        if (!idl_ff[pick_idx][can_buf_pkg::IDL_EXT_BIT]) begin
            tx_req_out.id = {18'h00000, idh_ff[pick_idx], idl_ff[pick_idx][7:5]};
        end
    end

    assign abort_req_out = abort_ff & sending_ff;

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_ff <= can_buf_pkg::RESET_BYTE;
        end else if (rd_in) begin
            if (addr_in == can_buf_pkg::ADDR_DIR) begin
                rdata_ff <= {2'h0, dir_tx_ff};
            end else if (addr_in == can_buf_pkg::ADDR_MODE) begin
                rdata_ff <= {6'h00, mode_ff};
            end else if (addr_in == can_buf_pkg::ADDR_TX_STAT) begin
                rdata_ff <= {2'h0, sending_ff};
            end else if (int'(wr_buf) < N && addr_in[3:2] == 2'h0 && enhanced &&
                         wr_reg == can_buf_pkg::REG_CON) begin
                rdata_ff <= con_ff[wr_buf];
            end else if (int'(wr_buf) < N && addr_in[3:2] == 2'h0 && enhanced &&
                         wr_reg == can_buf_pkg::REG_IDH) begin
                rdata_ff <= idh_ff[wr_buf];
            end else if (int'(wr_buf) < N && addr_in[3:2] == 2'h0 && enhanced &&
                         wr_reg == can_buf_pkg::REG_IDL) begin
                rdata_ff <= idl_ff[wr_buf];
            end else begin
                rdata_ff <= 8'h00;
            end
        end
    end

    assign rdata_out = rdata_ff;
endmodule

// [verilog/tx_prio_pick.sv]
// Picks the pending transmit buffer with the highest priority
`timescale 1ns/1ps
module tx_prio_pick (
    input wire logic [5:0] pending_in,
    input wire logic [11:0] prio_in,
    output logic found_out,
    output logic [2:0] idx_out
);
    logic [1:0] best;

    // Ties go to the lower buffer number
    always_comb begin
        found_out = 1'b0;
        idx_out = 3'h0;
        best = 2'h0;
        for (int i = 0; i < 6; i++) begin
            if (pending_in[i] && (!found_out || prio_in[2*i +: 2] > best)) begin
                found_out = 1'b1;
                idx_out = 3'(i);
                best = prio_in[2*i +: 2];
            end
        end
    end
endmodule
